// [hdl/gedp_top.sv]
// six-pin general-purpose port with edge detection and read-to-clear status
`timescale 1ns/1ns
`default_nettype none
module gedp_top
   import gedp_pkg::*;
(
   input  wire logic [GEDP_AW-1:0]   reg_addr_i,
   input  wire logic                 reg_wr_i,
   input  wire logic [GEDP_DW-1:0]   reg_wdata_i,
   input  wire logic                 reg_rd_i,
   output var  logic [GEDP_DW-1:0]   reg_rdata_o,
   output var  logic                 reg_rvalid_o,
   input  wire logic [GEDP_PINS-1:0] pin_in_i,
   output var  logic [GEDP_PINS-1:0] pin_out_o,
   output var  logic [GEDP_PINS-1:0] pin_oe_o,
   input  wire logic                 ref_clk_i,
   input  wire logic                 srst_i
);
   // address match, shared by write and read decode
   function automatic logic gedp_hit(input logic [GEDP_AW-1:0] addr, input logic [7:0] ofs);
      gedp_hit = (addr == ofs);
   endfunction : gedp_hit

   gedp_pin_if pif ();

   logic [GEDP_PINS-1:0] pin_en;
   logic [GEDP_PINS-1:0] pin_dir;
   logic [GEDP_PINS-1:0] output_level_bits;
   logic [GEDP_PINS-1:0] rise_detect_enable;
   logic [GEDP_PINS-1:0] fall_detect_enable;
   logic [GEDP_PINS-1:0] rise_seen_flags;
   logic [GEDP_PINS-1:0] fall_seen_flags;

   gedp_edge_detect u_det (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .pif       (pif)
   );

   // configuration out to the detector, raw pins in
   assign pif.pin_raw = pin_in_i;
   assign pif.pin_en  = pin_en;
   assign pif.pin_dir = pin_dir;
   assign pif.rise_en = rise_detect_enable;
   assign pif.fall_en = fall_detect_enable;

   // register decode
   wire hit_ctrl  = gedp_hit(reg_addr_i, GEDP_OFS_CTRL);
   wire hit_edge  = gedp_hit(reg_addr_i, GEDP_OFS_EDGE);
   wire hit_stat  = gedp_hit(reg_addr_i, GEDP_OFS_STAT);
   wire wr_ctrl   = reg_wr_i & hit_ctrl;
   wire wr_edge   = reg_wr_i & hit_edge;
   wire rd_stat   = reg_rd_i & hit_stat;

   // assembled read words; reserved bits read zero
   wire [GEDP_DW-1:0] word_ctrl = {2'h0, pin_en, 2'h0, pin_dir, 2'h0, output_level_bits};
   wire [GEDP_DW-1:0] word_edge = {2'h0, rise_detect_enable, 2'h0, fall_detect_enable, 8'h00};
   wire [GEDP_DW-1:0] word_stat = {2'h0, rise_seen_flags, 2'h0, fall_seen_flags, 2'h0, pif.level};
   wire [GEDP_DW-1:0] rd_word   = hit_ctrl ? word_ctrl :
                                  hit_edge ? word_edge :
                                  hit_stat ? word_stat : GEDP_RST_WORD;   // unmapped reads zero

   // read clears, but an edge in the same cycle is kept: set wins
   wire [GEDP_PINS-1:0] next_rise = (rise_seen_flags & {GEDP_PINS{~rd_stat}}) | pif.rise;
   wire [GEDP_PINS-1:0] next_fall = (fall_seen_flags & {GEDP_PINS{~rd_stat}}) | pif.fall;

   // pin drive: only enabled output pins drive
   wire [GEDP_PINS-1:0] next_oe  = pin_en & pin_dir;
   wire [GEDP_PINS-1:0] next_out = next_oe & output_level_bits;

   // control register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pin_en            <= GEDP_RST_FIELD;
         pin_dir           <= GEDP_RST_FIELD;
         output_level_bits <= GEDP_RST_FIELD;
      end else if (wr_ctrl) begin
         pin_en            <= reg_wdata_i[GEDP_POS_HI +: GEDP_PINS];
         pin_dir           <= reg_wdata_i[GEDP_POS_MID +: GEDP_PINS];
         output_level_bits <= reg_wdata_i[GEDP_POS_LO +: GEDP_PINS];
      end
   end

   // edge detect enable register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rise_detect_enable <= GEDP_RST_FIELD;
         fall_detect_enable <= GEDP_RST_FIELD;
      end else if (wr_edge) begin
         rise_detect_enable <= reg_wdata_i[GEDP_POS_HI +: GEDP_PINS];
         fall_detect_enable <= reg_wdata_i[GEDP_POS_MID +: GEDP_PINS];
      end
   end

   // sticky seen flags
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rise_seen_flags <= GEDP_RST_FIELD;
         fall_seen_flags <= GEDP_RST_FIELD;
      end else begin
         rise_seen_flags <= next_rise;
         fall_seen_flags <= next_fall;
      end
   end

   // read answer registered one cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reg_rdata_o  <= GEDP_RST_WORD;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rdata_o  <= reg_rd_i ? rd_word : GEDP_RST_WORD;
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // pad drive registered so pins never glitch on decode
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pin_oe_o  <= GEDP_RST_FIELD;
         pin_out_o <= GEDP_RST_FIELD;
      end else begin
         pin_oe_o  <= next_oe;
         pin_out_o <= next_out;
      end
   end

   // checks on the pin and register behaviour
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   property p_reset_clears;
      disable iff (1'b0)
      srst_i |=> (pin_en == 6'h00) && (pin_dir == 6'h00) && (output_level_bits == 6'h00)
                 && (pin_oe_o == 6'h00);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left configuration set");

   property p_ctrl_write;
      wr_ctrl |=> ##1 (pin_oe_o == ($past(reg_wdata_i[21:16], 2) & $past(reg_wdata_i[13:8], 2)));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("enable or direction not applied");

   property p_drive;
      ##1 (pin_out_o == ($past(pin_en) & $past(pin_dir) & $past(output_level_bits)))
          && ((pin_out_o & ~pin_oe_o) == 6'h00);
   endproperty
   a_drive: assert property (p_drive) else $error("output pin level wrong");

   property p_oe_dir;
      ##1 (pin_oe_o == $past(pin_en & pin_dir));
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("output enable does not follow direction");

   property p_no_edge_off;
      ((pif.rise | pif.fall | pif.level) & (pin_dir | ~pin_en)) == 6'h00;
   endproperty
   a_no_edge_off: assert property (p_no_edge_off) else $error("output or disabled pin reported");

   property p_rise_sets;
      (pif.rise != 6'h00) |=> ((rise_seen_flags & $past(pif.rise)) == $past(pif.rise));
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rise edge lost");

   property p_fall_sets;
      (pif.fall != 6'h00) |=> ((fall_seen_flags & $past(pif.fall)) == $past(pif.fall));
   endproperty
   a_fall_sets: assert property (p_fall_sets) else $error("fall edge lost");

   property p_sticky;
      !rd_stat |=> ((rise_seen_flags & $past(rise_seen_flags)) == $past(rise_seen_flags))
                   && ((fall_seen_flags & $past(fall_seen_flags)) == $past(fall_seen_flags));
   endproperty
   a_sticky: assert property (p_sticky) else $error("seen flag dropped without read");

   property p_read_clears;
      rd_stat && (pif.rise == 6'h00) && (pif.fall == 6'h00)
         |=> (rise_seen_flags == 6'h00) && (fall_seen_flags == 6'h00) && reg_rvalid_o;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

   property p_level_read;
      rd_stat |=> reg_rvalid_o && (reg_rdata_o[5:0] == $past(pif.level))
                  && (reg_rdata_o[21:16] == $past(rise_seen_flags));
   endproperty
   a_level_read: assert property (p_level_read) else $error("status word wrong");

   property p_disabled_quiet;
      (pin_en == 6'h00) |=> (pin_oe_o == 6'h00) && (pin_out_o == 6'h00);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled pin drives");

   c_rise_seen:  cover property (pif.rise != 6'h00 ##1 rise_seen_flags != 6'h00);
   c_fall_seen:  cover property (pif.fall != 6'h00 ##1 fall_seen_flags != 6'h00);
   c_read_clear: cover property ((rise_seen_flags != 6'h00) && rd_stat);
   c_drive_high: cover property (pin_out_o != 6'h00);
endmodule : gedp_top
`default_nettype wire

// [hdl/gedp_pkg.sv]
// constants, register map and field layout of the six-pin edge detecting port
package gedp_pkg;
   localparam int unsigned GEDP_PINS      = 6;
   localparam int unsigned GEDP_AW        = 8;
   localparam int unsigned GEDP_DW        = 24;

   // register offsets
   localparam logic [7:0]  GEDP_OFS_CTRL  = 8'h04;
   localparam logic [7:0]  GEDP_OFS_EDGE  = 8'h05;
   localparam logic [7:0]  GEDP_OFS_STAT  = 8'h06;

   // field positions (low bit of each six-bit field)
   localparam int unsigned GEDP_POS_HI    = 16;
   localparam int unsigned GEDP_POS_MID   = 8;
   localparam int unsigned GEDP_POS_LO    = 0;

   // reset values
   localparam logic [5:0]  GEDP_RST_FIELD = 6'h00;
   localparam logic [23:0] GEDP_RST_WORD  = 24'h000000;

   // two flip-flop stages before any logic sees a pin
   localparam int unsigned GEDP_SYNC_LEN  = 2;
endpackage : gedp_pkg

// [hdl/gedp_pin_if.sv]
// carrier between the register core and the pin edge detector
`timescale 1ns/1ns
`default_nettype none
interface gedp_pin_if;
   import gedp_pkg::*;
   logic [GEDP_PINS-1:0] pin_raw;
   logic [GEDP_PINS-1:0] pin_en;
   logic [GEDP_PINS-1:0] pin_dir;
   logic [GEDP_PINS-1:0] rise_en;
   logic [GEDP_PINS-1:0] fall_en;
   logic [GEDP_PINS-1:0] level;
   logic [GEDP_PINS-1:0] rise;
   logic [GEDP_PINS-1:0] fall;

   modport det (
      input  pin_raw,
      input  pin_en,
      input  pin_dir,
      input  rise_en,
      input  fall_en,
      output level,
      output rise,
      output fall
   );

   modport core (
      output pin_raw,
      output pin_en,
      output pin_dir,
      output rise_en,
      output fall_en,
      input  level,
      input  rise,
      input  fall
   );
endinterface : gedp_pin_if
`default_nettype wire

// [hdl/gedp_edge_detect.sv]
// per-pin synchroniser, edge detector and enable/direction gating
`timescale 1ns/1ns
`default_nettype none
module gedp_edge_detect
   import gedp_pkg::*;
(
   input  wire logic  ref_clk_i,
   input  wire logic  srst_i,
   gedp_pin_if.det    pif
);
   genvar g;
   generate
      for (g = 0; g < GEDP_PINS; g = g + 1) begin : g_pin
         logic meta;
         logic sync;
         logic prev;
         wire  listen;

         // meta feeds only sync; prev holds the last settled level
         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               meta <= 1'b0;
               sync <= 1'b0;
               prev <= 1'b0;
            end else begin
               meta <= pif.pin_raw[g];
               sync <= meta;
               prev <= sync;
            end
         end

         // only enabled input pins are observed
         assign listen        = pif.pin_en[g] & ~pif.pin_dir[g];
         assign pif.level[g]  = sync & listen;
         assign pif.rise[g]   = sync & ~prev & listen & pif.rise_en[g];
         assign pif.fall[g]   = ~sync & prev & listen & pif.fall_en[g];
      end
   endgenerate
endmodule : gedp_edge_detect
`default_nettype wire

// [dv/gedp_pin_model.sv]
// external signal sources on the six port pins
`timescale 1ns/1ns
`default_nettype none
module gedp_pin_model
   import gedp_pkg::*;
(
   input  wire logic [GEDP_PINS-1:0] ext_level_i,
   input  wire logic [GEDP_PINS-1:0] pin_out_i,
   input  wire logic [GEDP_PINS-1:0] pin_oe_i,
   output var  logic [GEDP_PINS-1:0] pin_wire_o
);
   // wire level: a driving port wins, else the outside source sets the pin
   // so an output pin toggling on the wire must not look like an input edge
   always_comb begin
      pin_wire_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_level_i);
   end
endmodule : gedp_pin_model
`default_nettype wire

// [dv/test_gpio_edge_detect_port.sv]
// register level testbench of the six-pin edge detecting port
`timescale 1ns/1ns
`default_nettype none
module test_gpio_edge_detect_port;
   import gedp_pkg::*;
   logic                 ref_clk_i = 1'b0;
   logic                 srst_i    = 1'b1;
   logic [GEDP_AW-1:0]   addr      = 8'h00;
   logic                 wr_s      = 1'b0;
   logic                 rd_s      = 1'b0;
   logic [GEDP_DW-1:0]   wdata     = 24'h000000;
   logic [GEDP_DW-1:0]   rdata;
   logic                 rvalid;
   logic [GEDP_PINS-1:0] ext       = 6'h00;
   logic [GEDP_PINS-1:0] pin_wire;
   logic [GEDP_PINS-1:0] pin_out;
   logic [GEDP_PINS-1:0] pin_oe;
   int                   n_errors  = 0;
   int                   n_tests   = 0;
   int                   cycles    = 0;

   gedp_top gedp_top_i (
      .reg_addr_i   (addr),
      .reg_wr_i     (wr_s),
      .reg_wdata_i  (wdata),
      .reg_rd_i     (rd_s),
      .reg_rdata_o  (rdata),
      .reg_rvalid_o (rvalid),
      .pin_in_i     (pin_wire),
      .pin_out_o    (pin_out),
      .pin_oe_o     (pin_oe),
      .ref_clk_i    (ref_clk_i),
      .srst_i       (srst_i)
   );

   gedp_pin_model gedp_pin_model_i (
      .ext_level_i (ext),
      .pin_out_i   (pin_out),
      .pin_oe_i    (pin_oe),
      .pin_wire_o  (pin_wire)
   );

   // 20 MHz clock
   always #25 ref_clk_i = ~ref_clk_i;

   // hang guard, the whole sequence needs well under 400 cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // bench always stands 2 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #2;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      addr  = a;
      wdata = d;
      wr_s  = 1'b1;
      cyc(1);
      wr_s  = 1'b0;
      cyc(1);   // idle edge, so a following strobe never rises in the same step
   endtask : wr

   // answer is due exactly one cycle after the strobe is taken
   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      addr = a;
      rd_s = 1'b1;
      cyc(1);
      rd_s = 1'b0;
      chk("rvalid", {23'h0, rvalid}, 24'h000001);
      d = rdata;
      cyc(1);
      // the answer stands one cycle only, then both return to zero
      chk("rvalid_end", {23'h0, rvalid}, 24'h000000);
      chk("rdata_end", rdata, 24'h000000);
   endtask : rd

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [23:0] exp);
      logic [23:0] v;
      rd(a, v);
      chk(nm, v, exp);
   endtask : rd_chk

   task automatic pins(input logic [5:0] oe, input logic [5:0] out);
      cyc(2);
      chk("pin_oe", {18'h0, pin_oe}, {18'h0, oe});
      chk("pin_out", {18'h0, pin_out}, {18'h0, out});
   endtask : pins

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   initial begin
      cyc(4);
      srst_i = 1'b0;
      // reset state
      chk("oe_rst", {18'h0, pin_oe}, 24'h000000);
      rd_chk("ctrl_rst", GEDP_OFS_CTRL, GEDP_RST_WORD);
      rd_chk("edge_rst", GEDP_OFS_EDGE, 24'h000000);
      rd_chk("unmapped", 8'h10, 24'h000000);
      // reserved bits drop, all pins driven high
      wr(GEDP_OFS_CTRL, 24'hFFFFFF);
      pins(6'h3F, 6'h3F);
      rd_chk("ctrl_rb", GEDP_OFS_CTRL, 24'h3F3F3F);
      // mixed enable and direction
      wr(GEDP_OFS_CTRL, 24'h0F3C2A);
      pins(6'h0C, 6'h08);
      // pins 4,5 outputs, pins 0..3 inputs; pin 3 stops driving high here,
      // so detection is armed only once its falling wire has passed the chain
      wr(GEDP_OFS_CTRL, 24'h3F3030);
      cyc(5);
      wr(GEDP_OFS_EDGE, 24'h3F3F00);
      // output pins toggle on the wire while detection is armed
      wr(GEDP_OFS_CTRL, 24'h3F3000);
      pins(6'h30, 6'h00);
      cyc(3);
      wr(GEDP_OFS_CTRL, 24'h3F3030);
      pins(6'h30, 6'h30);
      cyc(3);
      rd_chk("stat_quiet", GEDP_OFS_STAT, 24'h000000);
      ext = 6'h05;
      cyc(5);
      rd_chk("stat_rise", GEDP_OFS_STAT, 24'h050005);
      rd_chk("stat_clr", GEDP_OFS_STAT, 24'h000005);
      ext = 6'h00;
      cyc(5);
      ext = 6'h05;
      cyc(5);
      rd_chk("stat_both", GEDP_OFS_STAT, 24'h050505);
      // per-pin detect masks
      wr(GEDP_OFS_EDGE, 24'h010200);
      rd_chk("edge_rb", GEDP_OFS_EDGE, 24'h010200);
      ext = 6'h00;
      cyc(5);
      rd_chk("stat_low", GEDP_OFS_STAT, 24'h000000);
      ext = 6'h0F;
      cyc(5);
      ext = 6'h00;
      cyc(5);
      rd_chk("stat_mask", GEDP_OFS_STAT, 24'h010200);
      // disabled pin 3 reports neither level nor edge
      wr(GEDP_OFS_EDGE, 24'h3F3F00);
      wr(GEDP_OFS_CTRL, 24'h373030);
      pins(6'h30, 6'h30);
      ext = 6'h08;
      cyc(5);
      rd_chk("stat_dis", GEDP_OFS_STAT, 24'h000000);
      // mid-run reset returns every field to its cleared value
      srst_i = 1'b1;
      cyc(2);
      srst_i = 1'b0;
      chk("oe_rst2", {18'h0, pin_oe}, 24'h000000);
      rd_chk("ctrl_rst2", GEDP_OFS_CTRL, GEDP_RST_WORD);
      rd_chk("edge_rst2", GEDP_OFS_EDGE, 24'h000000);
      final_report();
   end
endmodule : test_gpio_edge_detect_port
`default_nettype wire
